/* hdl/iobc_dev.sv */
// I/O controller end: cycle decode, strobes, selects and buffer control
module iobc_dev #(
  parameter int STRB_SLOW = iobc_pkg::STRB_SLOW_CYC,
  parameter int STRB_MEDIUM = iobc_pkg::STRB_MEDIUM_CYC,
  parameter int STRB_FAST = iobc_pkg::STRB_FAST_CYC,
  parameter int STRB_SYNC = iobc_pkg::STRB_SYNC_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  iobc_if.dev bus,
  output logic sys_clk_buf,
  output logic periph_clk_div4,
  input wire logic data_latch_ctrl_in,
  output logic data_latch_ctrl_out,
  output logic data_latch_ctrl_oe_n,
  output logic ext_buffer_select_n,
  output logic [7:1] periph_select,
  output logic rd_buffer_en_n,
  output logic wr_buffer_en_n,
  output logic periph_rd_strobe_n,
  output logic periph_wr_strobe_n,
  input wire logic [7:0] periph_data_in,
  output logic [7:0] periph_data_out,
  output logic periph_data_oe_n,
  output logic reg_rd,
  output logic reg_wr,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Clocks

  logic div4_tick;

  iobc_clkgen u_clkgen (
    .core_clk(core_clk),
    .rst(rst),
    .sys_clk_buf(sys_clk_buf),
    .periph_clk_div4(periph_clk_div4),
    .div4_tick(div4_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic [7:1] bank_onehot(input logic [2:0] bank);
    logic [7:0] full;
    full = 8'h01 << bank;
    return full[7:1];
  endfunction

  function automatic logic [3:0] strobe_len(input logic [1:0] ctype);
    logic [3:0] len;
    unique case (ctype)
      iobc_pkg::TYPE_SLOW: len = 4'(STRB_SLOW);
      iobc_pkg::TYPE_MEDIUM: len = 4'(STRB_MEDIUM);
      iobc_pkg::TYPE_FAST: len = 4'(STRB_FAST);
      iobc_pkg::TYPE_SYNC: len = 4'(STRB_SYNC);
    endcase
    return len;
  endfunction

  iobc_pkg::iobc_dev_state_e state_q, state_d;
  logic [3:0] cnt_q;
  logic write_q;
  logic [1:0] type_q;
  logic [2:0] bank_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] pdata_s1_q;
  logic [7:0] pdata_s2_q;

  wire req_active = !bus.io_cycle_request_n;
  wire bank_is_int = (bus.bank_sel == iobc_pkg::BANK_INTERNAL);
  wire start_int = req_active && bus.chip_select && bank_is_int;
  wire start_ext = req_active && bus.chip_select && !bank_is_int;
  wire in_idle = (state_q == iobc_pkg::IOBC_IDLE);
  wire in_setup = (state_q == iobc_pkg::IOBC_SETUP);
  wire in_strobe = (state_q == iobc_pkg::IOBC_STROBE);
  wire in_grant = (state_q == iobc_pkg::IOBC_GRANT);
  wire in_release = (state_q == iobc_pkg::IOBC_RELEASE);
  wire in_int = (state_q == iobc_pkg::IOBC_INTERNAL);
  wire is_sync = (type_q == iobc_pkg::TYPE_SYNC);
  wire ext_busy = (in_setup || in_strobe || in_grant || in_release)
                  && (bank_q != iobc_pkg::BANK_INTERNAL);
  wire strobe_done = in_strobe && (cnt_q == 4'h1);
  // Synchronous cycles wait for a peripheral clock boundary
  wire setup_go = !is_sync || div4_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      iobc_pkg::IOBC_IDLE: begin
        if (start_int) begin
          state_d = iobc_pkg::IOBC_INTERNAL;
        end else if (start_ext) begin
          state_d = iobc_pkg::IOBC_SETUP;
        end
      end
      iobc_pkg::IOBC_INTERNAL: state_d = iobc_pkg::IOBC_GRANT;
      iobc_pkg::IOBC_SETUP: begin
        if (setup_go) begin
          state_d = iobc_pkg::IOBC_STROBE;
        end
      end
      iobc_pkg::IOBC_STROBE: begin
        if (strobe_done) begin
          state_d = iobc_pkg::IOBC_GRANT;
        end
      end
      iobc_pkg::IOBC_GRANT: begin
        if (req_active) begin
          state_d = iobc_pkg::IOBC_RELEASE;
        end else begin
          state_d = iobc_pkg::IOBC_IDLE;
        end
      end
      iobc_pkg::IOBC_RELEASE: begin
        // Hold off until the request drops, so one request is one cycle
        if (!req_active) begin
          state_d = iobc_pkg::IOBC_IDLE;
        end
      end
      default: state_d = iobc_pkg::IOBC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= iobc_pkg::IOBC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else if (in_setup) begin
      cnt_q <= strobe_len(type_q);
    end else if (in_strobe) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_q <= 1'b0;
      type_q <= iobc_pkg::TYPE_SLOW;
      bank_q <= iobc_pkg::BANK_INTERNAL;
      wdata_q <= iobc_pkg::DATA_RST;
    end else if (in_idle && req_active) begin
      write_q <= bus.write_dir;
      type_q <= bus.cycle_type;
      bank_q <= bus.bank_sel;
      wdata_q <= bus.cpu_data_byte;
    end
  end

  // Peripheral data comes from pins: two stages before use
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pdata_s1_q <= iobc_pkg::DATA_RST;
      pdata_s2_q <= iobc_pkg::DATA_RST;
    end else begin
      pdata_s1_q <= periph_data_in;
      pdata_s2_q <= pdata_s1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= iobc_pkg::DATA_RST;
    end else if (in_int && !write_q) begin
      rdata_q <= reg_rdata;
    end else if (strobe_done && !write_q) begin
      rdata_q <= pdata_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus.io_cycle_grant_n_out = 1'b0;
  assign bus.io_cycle_grant_n_oe_n = !in_grant;
  assign bus.dev_data_out = rdata_q;
  assign bus.dev_data_oe_n = !(in_grant && !write_q);

  assign reg_rd = in_int && !write_q;
  assign reg_wr = in_int && write_q;
  assign reg_addr = bus.reg_index;
  assign reg_wdata = wdata_q;

  // Latch closes for the whole external write, and from the
  // end of the read strobe so the peripheral byte is held
  wire latch_low = ext_busy && (write_q || in_grant || in_release);
  assign data_latch_ctrl_out = 1'b0;
  assign data_latch_ctrl_oe_n = !latch_low;

  assign ext_buffer_select_n = !ext_busy;
  assign periph_select = ext_busy ? bank_onehot(bank_q) : 7'h00;
  assign periph_rd_strobe_n = !(in_strobe && !write_q);
  assign periph_wr_strobe_n = !(in_strobe && write_q);
  assign periph_data_out = wdata_q;
  assign periph_data_oe_n = !(ext_busy && write_q);

  // Buffer enables follow the request even when not selected
  assign rd_buffer_en_n = !(req_active && !bus.write_dir
                            && !ext_busy && !start_ext);
  assign wr_buffer_en_n = !(req_active && bus.write_dir
                            && !ext_busy && !start_ext);

endmodule

/* hdl/iobc_pkg.sv */
// Shared constants for the I/O bus cycle bridge
package iobc_pkg;

  localparam int DATA_W = 8;
  localparam int BANK_W = 3;
  localparam int INDEX_W = 5;
  localparam int TYPE_W = 2;
  localparam int SEL_W = 7;

  // Cycle type encodings
  localparam logic [1:0] TYPE_SLOW = 2'h0;
  localparam logic [1:0] TYPE_MEDIUM = 2'h1;
  localparam logic [1:0] TYPE_FAST = 2'h2;
  localparam logic [1:0] TYPE_SYNC = 2'h3;

  // Bank that addresses the internal registers
  localparam logic [2:0] BANK_INTERNAL = 3'h0;

  // Strobe lengths in reference clock periods per cycle type
  localparam int STRB_SLOW_CYC = 8;
  localparam int STRB_MEDIUM_CYC = 5;
  localparam int STRB_FAST_CYC = 3;
  localparam int STRB_SYNC_CYC = 4;
  localparam int STRB_CNT_W = 4;

  // Peripheral timing clock divide ratio
  localparam int PCLK_DIV = 4;
  localparam int PCLK_CNT_W = 2;

  // Reset values
  localparam logic [1:0] PCLK_CNT_RST = 2'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] BUS_IDLE = 8'hFF;

  // Device end states, Gray along idle-setup-strobe-grant-release
  typedef enum logic [2:0] {
    IOBC_IDLE = 3'h0,
    IOBC_SETUP = 3'h1,
    IOBC_STROBE = 3'h3,
    IOBC_GRANT = 3'h2,
    IOBC_RELEASE = 3'h6,
    IOBC_INTERNAL = 3'h4
  } iobc_dev_state_e;

  // Controller end states
  typedef enum logic {
    IOBC_H_IDLE = 1'b0,
    IOBC_H_REQ = 1'b1
  } iobc_host_state_e;

endpackage

/* hdl/iobc_if.sv */
// Bus between memory controller end and I/O controller end
interface iobc_if;
  logic io_cycle_request_n;
  logic [1:0] cycle_type;
  logic write_dir;
  logic [2:0] bank_sel;
  logic chip_select;
  logic [4:0] reg_index;
  logic io_cycle_grant_n_out;
  logic io_cycle_grant_n_oe_n;
  logic io_cycle_grant_n;
  logic [7:0] host_data_out;
  logic host_data_oe_n;
  logic [7:0] dev_data_out;
  logic dev_data_oe_n;
  logic [7:0] cpu_data_byte;

  // Open-drain grant with pull-up; data bus idles high
  assign io_cycle_grant_n = io_cycle_grant_n_oe_n ? 1'b1 :
                            io_cycle_grant_n_out;
  assign cpu_data_byte = !dev_data_oe_n ? dev_data_out :
                         !host_data_oe_n ? host_data_out :
                         iobc_pkg::BUS_IDLE;

  modport host (
    output io_cycle_request_n, cycle_type, write_dir, bank_sel,
    output chip_select, reg_index, host_data_out, host_data_oe_n,
    input io_cycle_grant_n, cpu_data_byte
  );

  modport dev (
    input io_cycle_request_n, cycle_type, write_dir, bank_sel,
    input chip_select, reg_index, cpu_data_byte, io_cycle_grant_n,
    output io_cycle_grant_n_out, io_cycle_grant_n_oe_n,
    output dev_data_out, dev_data_oe_n
  );
endinterface

/* hdl/iobc_clkgen.sv */
// Buffered and divided peripheral clocks
module iobc_clkgen (
  input wire logic core_clk,
  input wire logic rst,
  output logic sys_clk_buf,
  output logic periph_clk_div4,
  output logic div4_tick
);
  logic [1:0] cnt_q;

  // Inverted copy of the reference clock
  assign sys_clk_buf = ~core_clk;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= iobc_pkg::PCLK_CNT_RST;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // MSB of a free 2-bit count is the reference divided by four
  assign periph_clk_div4 = cnt_q[1];
  assign div4_tick = (cnt_q == 2'h3);
endmodule

/* hdl/iobc_host.sv */
// Memory controller end: issues one I/O cycle per request
module iobc_host (
  input wire logic core_clk,
  input wire logic rst,
  iobc_if.host bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_type,
  input wire logic [2:0] req_bank,
  input wire logic req_cs,
  input wire logic [4:0] req_index,
  input wire logic [7:0] req_wdata,
  output logic done,
  output logic [7:0] rdata
);
  iobc_pkg::iobc_host_state_e state_q;
  logic write_q;
  logic [1:0] type_q;
  logic [2:0] bank_q;
  logic cs_q;
  logic [4:0] index_q;
  logic [7:0] wdata_q;
  logic done_q;
  logic [7:0] rdata_q;

  wire in_req = (state_q == iobc_pkg::IOBC_H_REQ);
  wire complete = in_req && !bus.io_cycle_grant_n;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= iobc_pkg::IOBC_H_IDLE;
      done_q <= 1'b0;
    end else begin
      done_q <= complete;
      if (!in_req && req_valid) begin
        state_q <= iobc_pkg::IOBC_H_REQ;
      end else if (complete) begin
        state_q <= iobc_pkg::IOBC_H_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_q <= 1'b0;
      type_q <= iobc_pkg::TYPE_SLOW;
      bank_q <= iobc_pkg::BANK_INTERNAL;
      cs_q <= 1'b0;
      index_q <= 5'h00;
      wdata_q <= iobc_pkg::DATA_RST;
    end else if (!in_req && req_valid) begin
      write_q <= req_write;
      type_q <= req_type;
      bank_q <= req_bank;
      cs_q <= req_cs;
      index_q <= req_index;
      wdata_q <= req_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= iobc_pkg::DATA_RST;
    end else if (complete && !write_q) begin
      rdata_q <= bus.cpu_data_byte;
    end
  end

  assign req_ready = !in_req;
  assign done = done_q;
  assign rdata = rdata_q;
  assign bus.io_cycle_request_n = !in_req;
  assign bus.write_dir = write_q;
  assign bus.cycle_type = type_q;
  assign bus.bank_sel = bank_q;
  assign bus.chip_select = cs_q;
  assign bus.reg_index = index_q;
  assign bus.host_data_out = wdata_q;
  assign bus.host_data_oe_n = !(in_req && write_q);
endmodule

/* tb/iobc_chk.sv */
// Link assertions for the I/O bus cycle bridge
module iobc_chk #(
  parameter int STRB_SLOW = iobc_pkg::STRB_SLOW_CYC,
  parameter int STRB_MEDIUM = iobc_pkg::STRB_MEDIUM_CYC,
  parameter int STRB_FAST = iobc_pkg::STRB_FAST_CYC,
  parameter int STRB_SYNC = iobc_pkg::STRB_SYNC_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic io_cycle_request_n,
  input wire logic [1:0] cycle_type,
  input wire logic write_dir,
  input wire logic [2:0] bank_sel,
  input wire logic chip_select,
  input wire logic [4:0] reg_index,
  input wire logic io_cycle_grant_n,
  input wire logic host_data_oe_n,
  input wire logic dev_data_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Cycles since the request fell; grant must land at a fixed count, or in a window for sync cycles
  logic [7:0] lat_q;
  logic [7:0] lat_d;
  logic [7:0] lat_n;
  logic lat_ok;
  assign lat_d = io_cycle_request_n ? 8'h00 : lat_q + 8'h01;
  assign lat_n = 8'((cycle_type == iobc_pkg::TYPE_SLOW) ? STRB_SLOW :
                 (cycle_type == iobc_pkg::TYPE_MEDIUM) ? STRB_MEDIUM :
                 (cycle_type == iobc_pkg::TYPE_FAST) ? STRB_FAST :
                 STRB_SYNC) + 8'h02;
  // Sync cycles may wait up to three more cycles for the divided tick
  assign lat_ok = (bank_sel == iobc_pkg::BANK_INTERNAL) ? lat_q == 8'h02 :
                  (cycle_type == iobc_pkg::TYPE_SYNC) ?
                  (lat_q >= lat_n && lat_q <= lat_n + 8'h03) : lat_q == lat_n;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lat_q <= 8'h00;
    end else begin
      lat_q <= lat_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  a_grant_pulse: assert property (!io_cycle_grant_n |=> io_cycle_grant_n)
    else $error("grant held low longer than one cycle");
  a_grant_latency: assert property (!io_cycle_grant_n |-> lat_ok)
    else $error("grant at wrong cycle count");
  a_grant_on_req: assert property (!io_cycle_grant_n |->
    !io_cycle_request_n && chip_select)
    else $error("grant without selected request");
  a_req_release: assert property (!io_cycle_grant_n &&
    !io_cycle_request_n |=> io_cycle_request_n)
    else $error("request not raised after completion");
  a_read_drive: assert property (!io_cycle_grant_n && !write_dir
    |-> !dev_data_oe_n)
    else $error("read data not driven in grant cycle");
  a_data_window: assert property (!dev_data_oe_n |->
    !io_cycle_grant_n && !write_dir)
    else $error("device drives data outside read grant");
  a_no_contend: assert property (!host_data_oe_n |-> dev_data_oe_n)
    else $error("both ends drive the data bus");
  a_fields_held: assert property (!io_cycle_request_n &&
    !$past(io_cycle_request_n) |-> $stable({cycle_type, write_dir,
    bank_sel, chip_select, reg_index}))
    else $error("cycle fields changed during request");
  c_internal: cover property (!io_cycle_grant_n && bank_sel == 3'h0);
  c_sync: cover property (!io_cycle_grant_n && bank_sel != 3'h0 &&
    cycle_type == iobc_pkg::TYPE_SYNC);
  c_deselect: cover property (!io_cycle_request_n && !chip_select);
endmodule

/* tb/tb_io_bus_cycle_interface.sv */
// Self-checking bench for the I/O bus cycle bridge
module tb_io_bus_cycle_interface;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S_SLOW = iobc_pkg::STRB_SLOW_CYC;
  localparam int S_MED = iobc_pkg::STRB_MEDIUM_CYC;
  localparam int S_FAST = iobc_pkg::STRB_FAST_CYC;
  localparam int S_SYNC = iobc_pkg::STRB_SYNC_CYC;
  logic core_clk, rst, req_valid, req_ready, req_write, req_cs, done;
  logic [1:0] req_type;
  logic [2:0] req_bank;
  logic [4:0] req_index, reg_addr, addr_seen;
  logic [7:0] req_wdata, rdata, periph_data_in, periph_data_out;
  logic [7:0] reg_wdata, reg_rdata, wd_seen, n_rd, n_wr, n_regrd, n_regwr;
  logic sys_clk_buf, periph_clk_div4, latch_out, latch_oe_n, latch;
  logic ext_sel_n, rbuf_n, wbuf_n, rd_stb_n, wr_stb_n, pdata_oe_n;
  logic reg_rd, reg_wr, mon_on, got_done;
  logic saw_ext, saw_latch, saw_rbuf, saw_wbuf, saw_pdrv;
  logic [7:1] periph_select, sel_or;
  int n_mismatch, check_count;
  assign latch = latch_oe_n ? 1'b1 : latch_out;
  assign reg_rdata = {3'h5, reg_addr};
  iobc_if bus_if ();
  iobc_host u_iobc_host (.core_clk(core_clk), .rst(rst), .bus(bus_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_type(req_type), .req_bank(req_bank), .req_cs(req_cs),
    .req_index(req_index), .req_wdata(req_wdata), .done(done),
    .rdata(rdata));
  iobc_dev #(.STRB_SLOW(S_SLOW), .STRB_MEDIUM(S_MED), .STRB_FAST(S_FAST),
    .STRB_SYNC(S_SYNC)) u_iobc_dev (.core_clk(core_clk), .rst(rst),
    .bus(bus_if), .sys_clk_buf(sys_clk_buf),
    .periph_clk_div4(periph_clk_div4), .data_latch_ctrl_in(latch),
    .data_latch_ctrl_out(latch_out), .data_latch_ctrl_oe_n(latch_oe_n),
    .ext_buffer_select_n(ext_sel_n), .periph_select(periph_select),
    .rd_buffer_en_n(rbuf_n), .wr_buffer_en_n(wbuf_n),
    .periph_rd_strobe_n(rd_stb_n), .periph_wr_strobe_n(wr_stb_n),
    .periph_data_in(periph_data_in), .periph_data_out(periph_data_out),
    .periph_data_oe_n(pdata_oe_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  iobc_chk #(.STRB_SLOW(S_SLOW), .STRB_MEDIUM(S_MED), .STRB_FAST(S_FAST),
    .STRB_SYNC(S_SYNC)) u_iobc_chk (.core_clk(core_clk), .rst(rst),
    .io_cycle_request_n(bus_if.io_cycle_request_n),
    .cycle_type(bus_if.cycle_type), .write_dir(bus_if.write_dir),
    .bank_sel(bus_if.bank_sel), .chip_select(bus_if.chip_select),
    .reg_index(bus_if.reg_index), .io_cycle_grant_n(bus_if.io_cycle_grant_n),
    .host_data_oe_n(bus_if.host_data_oe_n),
    .dev_data_oe_n(bus_if.dev_data_oe_n));
  //////////////////////////////////////////////////////////////////////////
  // Sampled at the falling edge so flop updates have landed
  always @(negedge core_clk) begin
    if (mon_on) begin
      saw_ext |= !ext_sel_n;
      saw_latch |= !latch;
      saw_rbuf |= !rbuf_n;
      saw_wbuf |= !wbuf_n;
      saw_pdrv |= !pdata_oe_n;
      sel_or |= periph_select;
      n_rd += 8'(!rd_stb_n);
      n_wr += 8'(!wr_stb_n);
      n_regrd += 8'(reg_rd);
      n_regwr += 8'(reg_wr);
      if (reg_rd || reg_wr) addr_seen = reg_addr;
      if (reg_wr) wd_seen = reg_wdata;
      if (!wr_stb_n && !pdata_oe_n) wd_seen = periph_data_out;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic w, input logic [1:0] t, input logic [2:0] b,
    input logic c, input logic [4:0] i, input logic [7:0] d);
    @(posedge core_clk);
    {saw_ext, saw_latch, saw_rbuf, saw_wbuf, saw_pdrv, sel_or} = 12'h000;
    // Cleared so a missing pulse cannot reuse an earlier capture
    {addr_seen, wd_seen} = 13'h0000;
    {n_rd, n_wr, n_regrd, n_regwr} = 32'h0;
    mon_on = 1'b1;
    {req_write, req_type, req_bank, req_cs, req_index} <= {w, t, b, c, i};
    {req_wdata, periph_data_in} <= {d, ~d};
    req_valid <= 1'b1;
    @(negedge core_clk);
    for (int k = 0; k < 20 && req_ready !== 1'b1; k++) @(negedge core_clk);
    @(posedge core_clk);
    req_valid <= 1'b0;
    for (int k = 0; k < 40 && done !== 1'b1; k++) @(negedge core_clk);
    got_done = (done === 1'b1);
    #1 mon_on = 1'b0;
  endtask
  task automatic t_clocks;
    logic [7:0] pat, bpat;
    @(posedge periph_clk_div4);
    for (int k = 0; k < 8; k++) begin
      @(negedge core_clk);
      // Let the inverted clock settle after the edge
      #1;
      pat = {pat[6:0], periph_clk_div4};
      bpat = {bpat[6:0], sys_clk_buf};
    end
    chk(pat, 8'hCC);
    chk(bpat, 8'hFF);
    @(posedge core_clk);
    #1 chk(8'(sys_clk_buf), 8'h00);
    $display("test clocks done");
  endtask
  task automatic t_internal;
    run(1'b1, 2'h0, 3'h0, 1'b1, 5'h13, 8'hA5);
    chk({3'h0, addr_seen}, 8'h13);
    chk(wd_seen, 8'hA5);
    chk(n_regwr, 8'h01);
    chk(8'(got_done), 8'h01);
    chk({7'h00, saw_latch | saw_ext | (|sel_or)}, 8'h00);
    chk(8'(saw_wbuf), 8'h01);
    run(1'b0, 2'h0, 3'h0, 1'b1, 5'h07, 8'h00);
    chk(rdata, 8'hA7);
    chk(8'(saw_rbuf), 8'h01);
    chk(n_regrd, 8'h01);
    $display("test internal done");
  endtask
  task automatic t_external;
    logic [2:0] b;
    logic [7:0] d;
    logic w;
    int len;
    for (int j = 0; j < 8; j++) begin
      b = 3'(j % 7 + 1);
      d = 8'h3C ^ 8'(j * 17);
      w = j[0];
      len = (j < 2) ? S_SLOW : (j < 4) ? S_MED : (j < 6) ? S_FAST : S_SYNC;
      run(w, 2'(j >> 1), b, 1'b1, 5'h00, d);
      chk(8'(got_done & saw_ext & saw_latch), 8'h01);
      chk({sel_or, 1'b0}, 8'h01 << b);
      chk(w ? n_wr : n_rd, 8'(len));
      chk(w ? n_rd : n_wr, 8'h00);
      chk(w ? wd_seen : rdata, w ? d : ~d);
      chk(n_regrd + n_regwr, 8'h00);
      chk(8'(saw_pdrv), 8'(w));
      chk(8'(saw_rbuf | saw_wbuf), 8'h00);
    end
    $display("test external done");
  endtask
  // A request with chip select low never completes, so reset recovers it
  task automatic t_deselect;
    for (int j = 0; j < 2; j++) begin
      run(j[0], 2'h2, 3'h2, 1'b0, 5'h01, 8'h11);
      chk(8'(got_done | saw_latch | saw_ext | saw_pdrv), 8'h00);
      chk(8'(j[0] ? saw_wbuf : saw_rbuf), 8'h01);
      chk(n_rd + n_wr, 8'h00);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
    end
    $display("test deselect done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    // The tests need a few hundred cycles; this leaves a wide margin
    repeat (4000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {rst, req_valid, req_write, req_cs, mon_on} = 5'h10;
    {req_type, req_bank, req_index, req_wdata, periph_data_in} = 26'h0;
    {n_mismatch, check_count} = 64'h0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_clocks();
    t_internal();
    t_external();
    t_deselect();
    t_internal();
    complete_run();
  end
endmodule
